// ===== verilog/uwh_top.sv
// Write-uncorrectable command handler with task file over AXI4-Lite.
// Assumes a media engine that answers each request with a one-cycle ack.
//
// Summary of operation
// - Error LBA readback, byte chosen by HOB.
// - Time limit overrun sets error bit 0; checked only at each sector step, so one in the last sector goes unreported.
// - Opcode 45h marks sectors uncorrectable.
// - Feature 55h marks whole physical block pseudo.
// - Pseudo read: full recovery, then UNC and ERR.
// - Feature AAh flags only the given sector.
// - Flagged read sets UNC and ERR.
// - Other feature values abort the command.
// - All read command kinds check the marking.
// - Host write stores data, clears marking.
// - After write, verify the sector reads back.
// - Real media faults report matching error status.
// - Markings survive power cycles; the flip-flop table here keeps them across resets only.
// - Abort when the command cannot be processed.
// - Log pseudo markings, not flagged ones.
// - 16-bit count, zero means 65536.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module uwh_top
	import uwh_pkg::*;
#(
	parameter int          NSECT  = 64,
	parameter int          LPP    = 8,
	parameter int          NRD    = 9,
	parameter logic [71:0] RD_OPS = 72'hc8_25_c4_29_20_24_40_42_2b,
	parameter int          NWR    = 7,
	parameter logic [55:0] WR_OPS = 56'hca_35_c5_39_30_34_3b
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             med_req_o,
	output logic             med_wr_o,
	output logic [47:0]      med_lba_o,
	input  wire logic        med_ack_i,
	input  wire logic        med_err_i,
	output logic             irq_o
);
	localparam int IW = $clog2(NSECT);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]  feat;
	logic [15:0] cnt_reg;
	logic [15:0] sn;
	logic [15:0] cl;
	logic [15:0] ch;
	logic [15:0] cctl;
	logic [7:0]  cmd;
	logic        cmd_go;
	logic        hob;
	logic        wipe;
	logic [2:0]  irq_st;
	logic [2:0]  irq_en;
	logic [15:0] log_cnt;
	logic        aw_got;
	logic        w_got;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_wr;
	logic [31:0] next_rdata;
	logic        rd_hit;
	logic        wr_hit;
	uwh_state_t  state;
	uwh_kind_t   kind;
	logic [1:0]  mark_val;
	logic [47:0] cur_lba;
	logic [47:0] err_lba;
	logic [16:0] left;
	logic [7:0]  err_reg;
	logic [15:0] us_cnt;
	logic        tick;
	logic        tmo;
	logic [1:0]  tab_val;
	logic        tab_wr;
	logic [IW-1:0] tab_lo;
	logic [IW-1:0] tab_hi;
	logic [1:0]  tab_wval;
	logic [IW-1:0] idx;
	logic        in_tab;
	logic [NRD-1:0] rd_m;
	logic [NWR-1:0] wr_m;
	logic [47:0] lba;
	logic [7:0]  status;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign lba    = {ch[15:8], cl[15:8], sn[15:8], ch[7:0], cl[7:0], sn[7:0]};
	assign idx    = cur_lba[IW-1:0];
	assign in_tab = cur_lba < 48'(NSECT);
	assign tmo    = (cctl != 16'h0000) && (us_cnt >= cctl);
	assign status = {state != UWH_S_IDLE, state == UWH_S_IDLE, 1'b0, 1'b1, 3'b000, err_reg != 8'h00};

	for (genvar g = 0; g < NRD; g++) begin : g_rd
		assign rd_m[g] = cmd == RD_OPS[8*g +: 8];
	end
	for (genvar g = 0; g < NWR; g++) begin : g_wr
		assign wr_m[g] = cmd == WR_OPS[8*g +: 8];
	end

	uwh_tick #(.CYC(UWH_TICK_CYC)) u_tick (
		.sys_clk_i(sys_clk_i),
		.rst_n_i  (rst_n_i),
		.tick_o   (tick)
	);

	uwh_flag_tab #(.NSECT(NSECT), .IW(IW)) u_tab (
		.sys_clk_i(sys_clk_i),
		.wipe_i   (wipe),
		.wr_i     (tab_wr),
		.lo_i     (tab_lo),
		.hi_i     (tab_hi),
		.val_i    (tab_wval),
		.rd_idx_i (idx),
		.rd_val_o (tab_val)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign do_wr = aw_got && w_got && !s_axi_bvalid_o;
	assign wr_hit = awaddr_q[1:0] == 2'b00 && awaddr_q <= UWH_A_LOG && awaddr_q != UWH_A_STATUS
		&& awaddr_q != UWH_A_IRQ_ST;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_got          <= 1'b0;
			w_got           <= 1'b0;
			awaddr_q        <= 8'h00;
			wdata_q         <= 32'h0000_0000;
			wstrb_q         <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= UWH_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_got          <= 1'b1;
				awaddr_q        <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_got          <= 1'b1;
				wdata_q        <= s_axi_wdata_i;
				wstrb_q        <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (do_wr) begin
				aw_got         <= 1'b0;
				w_got          <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit ? UWH_OKAY : UWH_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_hit     = 1'b1;
		next_rdata = 32'h0000_0000;
		unique case (s_axi_araddr_i)
			UWH_A_FEAT:   next_rdata[7:0] = feat;
			UWH_A_COUNT:  next_rdata[15:0] = cnt_reg;
			UWH_A_SECNUM: next_rdata[7:0] = hob ? err_lba[31:24] : err_lba[7:0];
			UWH_A_CYLLO:  next_rdata[7:0] = hob ? err_lba[39:32] : err_lba[15:8];
			UWH_A_CYLHI:  next_rdata[7:0] = hob ? err_lba[47:40] : err_lba[23:16];
			UWH_A_CTRL:   next_rdata[UWH_CT_HOB] = hob;
			UWH_A_CCTL:   next_rdata[15:0] = cctl;
			UWH_A_CMD:    next_rdata[7:0] = cmd;
			UWH_A_STATUS: next_rdata[15:0] = {err_reg, status};
			UWH_A_IRQ_ST: next_rdata[2:0] = irq_st;
			UWH_A_IRQ_EN: next_rdata[2:0] = irq_en;
			UWH_A_LOG:    next_rdata[15:0] = log_cnt;
			UWH_A_IRQ_CLR: next_rdata = 32'h0000_0000;
			default:      rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= UWH_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= next_rdata;
			s_axi_rresp_o   <= rd_hit ? UWH_OKAY : UWH_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Task-file and control registers
	// ----------------------------------------------------------------
	// A command write while busy is dropped; the pending command keeps its latched LBA.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			feat    <= 8'h00;
			cnt_reg <= 16'h0000;
			sn      <= 16'h0000;
			cl      <= 16'h0000;
			ch      <= 16'h0000;
			cctl    <= UWH_RST_CCTL;
			cmd     <= 8'h00;
			cmd_go  <= 1'b0;
			hob     <= 1'b0;
			wipe    <= 1'b0;
			irq_en  <= UWH_RST_IRQ_EN;
		end else begin
			cmd_go <= 1'b0;
			wipe   <= 1'b0;
			if (do_wr && wr_hit) begin
				unique case (awaddr_q)
					UWH_A_FEAT:   feat <= 8'(merge({24'h0, feat}, wdata_q, wstrb_q));
					UWH_A_COUNT:  cnt_reg <= 16'(merge({16'h0, cnt_reg}, wdata_q, wstrb_q));
					UWH_A_SECNUM: sn <= 16'(merge({16'h0, sn}, wdata_q, wstrb_q));
					UWH_A_CYLLO:  cl <= 16'(merge({16'h0, cl}, wdata_q, wstrb_q));
					UWH_A_CYLHI:  ch <= 16'(merge({16'h0, ch}, wdata_q, wstrb_q));
					UWH_A_CCTL:   cctl <= 16'(merge({16'h0, cctl}, wdata_q, wstrb_q));
					UWH_A_IRQ_EN: irq_en <= 3'(merge({29'h0, irq_en}, wdata_q, wstrb_q));
					UWH_A_CTRL: begin
						if (wstrb_q[0]) begin
							hob  <= wdata_q[UWH_CT_HOB];
							wipe <= wdata_q[UWH_CT_WIPE];
						end
					end
					UWH_A_CMD: begin
						if (wstrb_q[0] && state == UWH_S_IDLE) begin
							cmd    <= wdata_q[7:0];
							cmd_go <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	always_comb begin
		tab_wr   = 1'b0;
		tab_lo   = idx;
		tab_hi   = idx;
		tab_wval = mark_val;
		if (state == UWH_S_STEP && kind == UWH_K_MARK && in_tab && !tmo) begin
			tab_wr = 1'b1;
			if (mark_val == UWH_MK_PSEUDO) begin
				tab_lo = idx & ~IW'(LPP - 1);
				tab_hi = tab_lo | IW'(LPP - 1);
			end
		end else if (state == UWH_S_VFY && med_ack_i && !med_err_i && in_tab) begin
			tab_wr   = 1'b1;
			tab_wval = UWH_MK_NONE;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			us_cnt <= 16'h0000;
		end else if (state == UWH_S_IDLE) begin
			us_cnt <= 16'h0000;
		end else if (tick && us_cnt != 16'hffff) begin
			us_cnt <= us_cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state     <= UWH_S_IDLE;
			kind      <= UWH_K_MARK;
			mark_val  <= UWH_MK_NONE;
			cur_lba   <= 48'h0;
			err_lba   <= 48'h0;
			left      <= 17'h0;
			err_reg   <= 8'h00;
			log_cnt   <= 16'h0000;
			med_req_o <= 1'b0;
			med_wr_o  <= 1'b0;
			med_lba_o <= 48'h0;
		end else begin
			unique case (state)
				UWH_S_IDLE: begin
					if (cmd_go) begin
						state   <= UWH_S_SETUP;
						err_reg <= 8'h00;
					end
				end
				UWH_S_SETUP: begin
					cur_lba <= lba;
					left    <= (cnt_reg == 16'h0000) ? UWH_CNT_ZERO : {1'b0, cnt_reg};
					state   <= UWH_S_STEP;
					if (cmd == UWH_OP_MARK) begin
						kind <= UWH_K_MARK;
						if (feat == UWH_FEAT_PSEUDO) begin
							mark_val <= UWH_MK_PSEUDO;
							log_cnt  <= log_cnt + 16'h0001;
						end else if (feat == UWH_FEAT_FLAG) begin
							mark_val <= UWH_MK_FLAG;
						end else begin
							state   <= UWH_S_FIN;
							err_reg <= 8'h04;
						end
					end else if (|rd_m) begin
						kind <= UWH_K_RD;
					end else if (|wr_m) begin
						kind <= UWH_K_WR;
					end else begin
						state   <= UWH_S_FIN;
						err_reg <= 8'h04;
					end
				end
				UWH_S_STEP: begin
					med_lba_o <= cur_lba;
					if (tmo) begin
						state   <= UWH_S_FIN;
						err_reg <= 8'h01;
						err_lba <= cur_lba;
					end else if (kind == UWH_K_MARK) begin
						if (in_tab) begin
							state <= UWH_S_NEXT;
						end else begin
							state   <= UWH_S_FIN;
							err_reg <= 8'h04;
							err_lba <= cur_lba;
						end
					end else if (kind == UWH_K_RD && tab_val == UWH_MK_FLAG && in_tab) begin
						state   <= UWH_S_FIN;
						err_reg <= 8'h40;
						err_lba <= cur_lba;
					end else begin
						med_req_o <= 1'b1;
						med_wr_o  <= kind == UWH_K_WR;
						state     <= UWH_S_WAIT;
					end
				end
				UWH_S_WAIT: begin
					if (med_ack_i) begin
						med_req_o <= 1'b0;
						if (kind == UWH_K_RD) begin
							if (med_err_i || (in_tab && tab_val == UWH_MK_PSEUDO)) begin
								state   <= UWH_S_FIN;
								err_reg <= 8'h40;
								err_lba <= cur_lba;
							end else begin
								state <= UWH_S_NEXT;
							end
						end else if (med_err_i) begin
							state   <= UWH_S_FIN;
							err_reg <= 8'h04;
							err_lba <= cur_lba;
						end else begin
							med_req_o <= 1'b1;
							med_wr_o  <= 1'b0;
							state     <= UWH_S_VFY;
						end
					end
				end
				UWH_S_VFY: begin
					if (med_ack_i) begin
						med_req_o <= 1'b0;
						if (med_err_i) begin
							state   <= UWH_S_FIN;
							err_reg <= 8'h40;
							err_lba <= cur_lba;
						end else begin
							state <= UWH_S_NEXT;
						end
					end
				end
				UWH_S_NEXT: begin
					if (left == 17'h1) begin
						state <= UWH_S_FIN;
					end else begin
						left    <= left - 17'h1;
						cur_lba <= cur_lba + 48'h1;
						state   <= UWH_S_STEP;
					end
				end
				UWH_S_FIN: begin
					state <= UWH_S_IDLE;
				end
				default: begin
					state <= UWH_S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_st <= 3'h0;
			irq_o  <= 1'b0;
		end else begin
			irq_st <= (irq_st & ~((do_wr && awaddr_q == UWH_A_IRQ_CLR && wstrb_q[0]) ? wdata_q[2:0] : 3'h0))
				| ((state == UWH_S_FIN) ? {err_reg[UWH_ER_CTLE], err_reg != 8'h00, 1'b1} : 3'h0);
			irq_o  <= |(irq_st & irq_en);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_bad_mark;
		state == UWH_S_SETUP && cmd == UWH_OP_MARK && feat != UWH_FEAT_PSEUDO && feat != UWH_FEAT_FLAG;
	endsequence
	sequence s_wr_ok;
		state == UWH_S_WAIT && kind == UWH_K_WR && med_ack_i && !med_err_i;
	endsequence

	property p_bad_mark;
		s_bad_mark |=> state == UWH_S_FIN && err_reg[UWH_ER_ABT] && status[UWH_ST_ERR] ##1 irq_st[UWH_IRQ_ERR];
	endproperty
	a_bad_mark: assert property (p_bad_mark) else $error("bad feature not aborted");
	property p_cnt_zero;
		state == UWH_S_SETUP && cnt_reg == 16'h0000 |=> left == UWH_CNT_ZERO;
	endproperty
	a_cnt_zero: assert property (p_cnt_zero) else $error("zero count not 65536");
	property p_flag_rd;
		state == UWH_S_STEP && kind == UWH_K_RD && in_tab && tab_val == UWH_MK_FLAG && !tmo
			|=> err_reg[UWH_ER_UNC] && !med_req_o && err_lba == $past(cur_lba);
	endproperty
	a_flag_rd: assert property (p_flag_rd) else $error("flagged read not failed");
	property p_tmo;
		state == UWH_S_STEP && tmo |=> err_reg[UWH_ER_CTLE] && state == UWH_S_FIN;
	endproperty
	a_tmo: assert property (p_tmo) else $error("time limit not reported");
	property p_pseudo_rd;
		state == UWH_S_WAIT && kind == UWH_K_RD && med_ack_i && in_tab && tab_val == UWH_MK_PSEUDO
			|=> err_reg[UWH_ER_UNC] ##1 state == UWH_S_IDLE;
	endproperty
	a_pseudo_rd: assert property (p_pseudo_rd) else $error("pseudo read not failed");
	property p_verify;
		s_wr_ok |=> state == UWH_S_VFY && med_req_o && !med_wr_o;
	endproperty
	a_verify: assert property (p_verify) else $error("write not verified");
	property p_log;
		state == UWH_S_SETUP && cmd == UWH_OP_MARK |=> log_cnt == $past(log_cnt) + 16'(feat == UWH_FEAT_PSEUDO);
	endproperty
	a_log: assert property (p_log) else $error("log count wrong");
	property p_pseudo_span;
		tab_wr && mark_val == UWH_MK_PSEUDO && state == UWH_S_STEP
			|-> tab_lo <= idx && idx <= tab_hi && tab_hi - tab_lo == IW'(LPP - 1) ##1 tab_val == UWH_MK_PSEUDO;
	endproperty
	a_pseudo_span: assert property (p_pseudo_span) else $error("pseudo span wrong");
	property p_bresp;
		(s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
			and (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o));
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response dropped");
endmodule

// ===== verilog/uwh_pkg.sv
// Constants, register map and state type for the write-uncorrectable handler.
// Assumes a single 25 MHz clock and byte addresses on an AXI4-Lite bus.
package uwh_pkg;

	// ----------------------------------------------------------------
	// Command and option codes
	// ----------------------------------------------------------------
	localparam logic [7:0] UWH_OP_MARK     = 8'h45;
	localparam logic [7:0] UWH_FEAT_PSEUDO = 8'h55;
	localparam logic [7:0] UWH_FEAT_FLAG   = 8'haa;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] UWH_A_FEAT    = 8'h00;
	localparam logic [7:0] UWH_A_COUNT   = 8'h04;
	localparam logic [7:0] UWH_A_SECNUM  = 8'h08;
	localparam logic [7:0] UWH_A_CYLLO   = 8'h0c;
	localparam logic [7:0] UWH_A_CYLHI   = 8'h10;
	localparam logic [7:0] UWH_A_CTRL    = 8'h14;
	localparam logic [7:0] UWH_A_CCTL    = 8'h18;
	localparam logic [7:0] UWH_A_CMD     = 8'h1c;
	localparam logic [7:0] UWH_A_STATUS  = 8'h20;
	localparam logic [7:0] UWH_A_IRQ_ST  = 8'h24;
	localparam logic [7:0] UWH_A_IRQ_EN  = 8'h28;
	localparam logic [7:0] UWH_A_IRQ_CLR = 8'h2c;
	localparam logic [7:0] UWH_A_LOG     = 8'h30;

	// ----------------------------------------------------------------
	// Field positions and values after reset
	// ----------------------------------------------------------------
	localparam int UWH_ST_BSY  = 7;
	localparam int UWH_ST_RDY  = 6;
	localparam int UWH_ST_DSC  = 4;
	localparam int UWH_ST_ERR  = 0;
	localparam int UWH_ER_UNC  = 6;
	localparam int UWH_ER_ABT  = 2;
	localparam int UWH_ER_CTLE = 0;
	localparam int UWH_CT_HOB  = 0;
	localparam int UWH_CT_WIPE = 1;
	localparam int UWH_IRQ_DONE = 0;
	localparam int UWH_IRQ_ERR  = 1;
	localparam int UWH_IRQ_TMO  = 2;
	localparam logic [2:0]  UWH_RST_IRQ_EN = 3'h0;
	localparam logic [15:0] UWH_RST_CCTL   = 16'h0000;
	localparam logic [16:0] UWH_CNT_ZERO   = 17'h10000;
	localparam logic [1:0]  UWH_OKAY   = 2'b00;
	localparam logic [1:0]  UWH_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// Marking codes and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] UWH_MK_NONE   = 2'b00;
	localparam logic [1:0] UWH_MK_PSEUDO = 2'b01;
	localparam logic [1:0] UWH_MK_FLAG   = 2'b10;
	localparam int UWH_CLK_NS  = 40;
	localparam int UWH_TICK_NS = 1000;
	localparam int UWH_TICK_CYC = (UWH_TICK_NS + UWH_CLK_NS - 1) / UWH_CLK_NS;

	typedef enum logic [1:0] {UWH_K_MARK = 2'b00, UWH_K_RD = 2'b01, UWH_K_WR = 2'b10} uwh_kind_t;
	typedef enum logic [2:0] {
		UWH_S_IDLE  = 3'b000,
		UWH_S_SETUP = 3'b001,
		UWH_S_STEP  = 3'b011,
		UWH_S_WAIT  = 3'b010,
		UWH_S_VFY   = 3'b110,
		UWH_S_NEXT  = 3'b111,
		UWH_S_FIN   = 3'b101
	} uwh_state_t;
endpackage

// ===== verilog/uwh_tick.sv
// Microsecond tick divider for the completion time limit.
// Assumes the system clock runs continuously.
`timescale 1ns/1ps
module uwh_tick #(
	parameter int CYC = 25
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	output logic      tick_o
);
	localparam int CW = $clog2(CYC + 1);
	logic [CW-1:0] cnt;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end else if (cnt == CW'(CYC - 1)) begin
			cnt    <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt + CW'(1);
			tick_o <= 1'b0;
		end
	end
endmodule

// ===== verilog/uwh_flag_tab.sv
// Per-sector marking table held in flip-flops.
// Assumes only an explicit wipe clears the whole table; reset leaves it untouched.
`timescale 1ns/1ps
module uwh_flag_tab
	import uwh_pkg::*;
#(
	parameter int NSECT = 64,
	parameter int IW    = 6
) (
	input  wire logic          sys_clk_i,
	input  wire logic          wipe_i,
	input  wire logic          wr_i,
	input  wire logic [IW-1:0] lo_i,
	input  wire logic [IW-1:0] hi_i,
	input  wire logic [1:0]    val_i,
	input  wire logic [IW-1:0] rd_idx_i,
	output logic      [1:0]    rd_val_o
);
	logic [1:0] vec [NSECT];

	// No reset here, so a marking outlives any reset of the block.
	for (genvar g = 0; g < NSECT; g++) begin : g_ent
		logic [1:0] ent;
		always_ff @(posedge sys_clk_i) begin
			if (wipe_i) begin
				ent <= UWH_MK_NONE;
			end else if (wr_i && lo_i <= IW'(g) && IW'(g) <= hi_i) begin
				ent <= val_i;
			end
		end
		assign vec[g] = ent;
	end

	assign rd_val_o = vec[rd_idx_i];
endmodule

// ===== testbench/uwh_media_model.sv
// Media engine model: answers each held request after a set number of cycles.
// Assumes the handler holds its request until the one-cycle acknowledge.
`timescale 1ns/1ps
module uwh_media_model (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        req_i,
	input  wire logic [47:0] lba_i,
	input  wire logic [7:0]  dly_i,
	input  wire logic [47:0] bad_lba_i,
	output logic             ack_o,
	output logic             err_o
);
	logic [7:0] cnt;
	logic       fire;

	assign fire = req_i && !ack_o && cnt >= dly_i;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt   <= 8'h00;
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end else begin
			ack_o <= fire;
			cnt   <= (req_i && !ack_o && !fire) ? cnt + 8'h01 : 8'h00;
			// The fault line means nothing away from the ack, so it toggles there.
			err_o <= fire ? (lba_i == bad_lba_i) : !err_o;
		end
	end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the handler: AXI4-Lite tasks and command sequences.
// Assumes the media model in its own file and the default opcode lists.
`timescale 1ns/1ps
module tb_top import uwh_pkg::*;;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [7:0]  dly = 8'h01;
	logic [47:0] bad = 48'hffff_ffff_ffff;
	logic        awready, wready, bvalid, arready, rvalid, mreq, mack, merr, irq;
	logic [1:0]  bresp, rresp, br, rr;
	logic [31:0] rdata, d;
	logic [47:0] mlba;
	logic        mwr;
	int          n_mwr = 0;
	logic [71:0] rops = 72'hc8_25_c4_29_20_24_40_42_2b;
	int          fail_count = 0;
	int          n_checks = 0;

	uwh_top i_uwh_top (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .med_req_o(mreq),
		.med_wr_o(mwr), .med_lba_o(mlba), .med_ack_i(mack), .med_err_i(merr), .irq_o(irq));
	uwh_media_model i_uwh_media_model (.sys_clk_i(clk), .rst_n_i(rst_n), .req_i(mreq), .lba_i(mlba),
		.dly_i(dly), .bad_lba_i(bad), .ack_o(mack), .err_o(merr));

	initial begin
		forever #20 clk = ~clk;
	end

	// Counts completed media writes, so the write direction line is checked.
	always @(posedge clk) begin
		if (mreq && mack && mwr) n_mwr++;
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		br = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	// Status is polled after a short settle so a command not yet busy is not read as finished.
	task automatic run(input logic [7:0] op, input logic [7:0] ft, input logic [47:0] lba,
		input logic [15:0] n, input logic [7:0] err);
		wr(UWH_A_IRQ_CLR, 32'h7);
		wr(UWH_A_FEAT, {24'h0, ft});
		wr(UWH_A_COUNT, {16'h0, n});
		wr(UWH_A_SECNUM, {16'h0, lba[31:24], lba[7:0]});
		wr(UWH_A_CYLLO, {16'h0, lba[39:32], lba[15:8]});
		wr(UWH_A_CYLHI, {16'h0, lba[47:40], lba[23:16]});
		wr(UWH_A_CMD, {24'h0, op});
		repeat (4) @(posedge clk);
		do rd(UWH_A_STATUS); while (d[UWH_ST_BSY] !== 1'b0);
		chk("status", d, {16'h0, err, 7'h28, |err});
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		#(40 * 60000);
		fail_count++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(UWH_A_IRQ_EN);
		chk("irq_en reset", d, {29'h0, UWH_RST_IRQ_EN});
		rd(UWH_A_CCTL);
		chk("cctl reset", d, {16'h0, UWH_RST_CCTL});
		rd(8'h3c);
		chk("unmapped resp", {30'h0, rr}, {30'h0, UWH_SLVERR});
		wr(UWH_A_STATUS, 32'h0);
		chk("ro write resp", {30'h0, br}, {30'h0, UWH_SLVERR});
		wr(UWH_A_CTRL, 32'h2);
		$display("test registers done");
		run(8'h45, 8'haa, 48'd5, 16'd1, 8'h00);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rd(UWH_A_LOG);
		chk("log flagged", d, 32'h0);
		wr(UWH_A_IRQ_EN, 32'h7);
		repeat (2) @(posedge clk);
		chk("irq raised", {31'h0, irq}, 32'h1);
		wr(UWH_A_IRQ_CLR, 32'h7);
		repeat (2) @(posedge clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("test flag mark done");
		run(8'h20, 8'h00, 48'd5, 16'd1, 8'h40);
		rd(UWH_A_SECNUM);
		chk("err lba", d, 32'h5);
		run(8'h45, 8'h55, 48'd17, 16'd1, 8'h00);
		rd(UWH_A_LOG);
		chk("log pseudo", d, 32'h1);
		run(8'h25, 8'h00, 48'd16, 16'd1, 8'h40);
		run(8'h25, 8'h00, 48'd24, 16'd1, 8'h00);
		$display("test pseudo mark done");
		run(8'h45, 8'h12, 48'd8, 16'd1, 8'h04);
		rd(UWH_A_IRQ_ST);
		chk("irq status", d, 32'h3);
		run(8'h30, 8'h00, 48'd5, 16'd1, 8'h00);
		run(8'h20, 8'h00, 48'd5, 16'd1, 8'h00);
		$display("test abort and write done");
		bad <= 48'd30;
		run(8'hc8, 8'h00, 48'd30, 16'd1, 8'h40);
		run(8'h35, 8'h00, 48'd30, 16'd1, 8'h04);
		chk("media writes", n_mwr, 32'h2);
		bad <= 48'hffff_ffff_ffff;
		run(8'h45, 8'haa, 48'd60, 16'd0, 8'h04);
		rd(UWH_A_SECNUM);
		chk("err lba end", d, 32'h40);
		run(8'h24, 8'h00, 48'd62, 16'd1, 8'h40);
		run(8'h45, 8'haa, 48'h0a00_0b00_0003, 16'd1, 8'h04);
		wr(UWH_A_CTRL, 32'h1);
		rd(UWH_A_CYLHI);
		chk("err lba 47:40", d, 32'h0a);
		rd(UWH_A_SECNUM);
		chk("err lba 31:24", d, 32'h0b);
		wr(UWH_A_CTRL, 32'h0);
		$display("test count and range done");
		dly <= 8'd30;
		wr(UWH_A_CCTL, 32'h1);
		run(8'hc8, 8'h00, 48'd40, 16'd4, 8'h01);
		wr(UWH_A_CCTL, 32'h0);
		dly <= 8'h01;
		$display("test time limit done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 8; i >= 0; i--) begin
			run(rops[i*8 +: 8], 8'h00, 48'd16, 16'd1, 8'h40);
		end
		$display("test read kinds done");
		end_of_test();
	end
endmodule
